// >>> sec_escape_config.sv
/*
  escape-sequence detector and serial configuration holder.
  serial bytes arrive from the receiver on sys_clk; the receive pin is
  also watched for start bits so that a half-received byte breaks
  the post silence. binary commands arrive from the command-mode parser on
  sys_clk. the uart divisor output feeds the serial transmitter and
  receiver outside this block.
*/
// Summary of operation
// - post guard time held, 16 bits
// - post guard resets to one second
// - silence required before escape character
// - escape character 0x20..0x7F, reset plus
// - silence, character, silence enters command mode
// - codes 0..6 decode to standard rates
// - literal rates stored at nearest achievable
// - new rate waits for exit command
// - radio rate untouched by rate change
// - rate query returns stored value, two bytes
// - rate resets to factory radio code
// - post guard two bytes, character one
// - codes 0x05 post, 0x04 pre guard
// - codes 0x15 rate, 0x13 character
// - character query returns one byte
// - exit ends command mode, applies rate
`timescale 1ns/1ps
`default_nettype none

`include "sec_regs.svh"

module sec_escape_config #(
  parameter int unsigned TICK_CYCLES =
    `SEC_GUARD_UNIT_NS / `SEC_CLK_PERIOD_NS,
  parameter logic [15:0] RF_RATE_CODE = 16'h0003
) (
  input  wire logic             sys_clk,          // 40 MHz clock
  input  wire logic             arst_n,           // async reset, low
  input  wire logic             serial_input_pin, // raw receive pin
  input  wire logic             rx_valid,         // received byte strobe
  input  wire logic [7:0]       rx_byte,          // received byte
  input  wire logic             cmd_valid,        // command strobe
  input  wire sec_pkg::sec_cmd_s cmd,             // command fields
  output logic                  rsp_valid,        // answer strobe
  output sec_pkg::sec_rsp_s     rsp,              // answer fields
  output logic                  data_valid,       // data byte strobe
  output logic [7:0]            data_byte,        // data byte
  output logic                  command_mode,     // command mode active
  output logic [15:0]           uart_divisor,     // active divisor
  output logic [15:0]           rate_active       // rate value in use
);
  import sec_pkg::*;

  localparam logic [31:0] RST_DIV32 =
    sec_divisor(sec_std_bps(RF_RATE_CODE[2:0]));
  localparam logic [15:0] RST_DIV = RST_DIV32[15:0];

  logic        rst_s1_reg, rst_n_reg;
  logic        pin_s1_reg, pin_s2_reg;
  logic [31:0] tick_cnt_reg;
  logic [15:0] silence_reg;
  logic        activity;
  sec_state_e  state_reg;
  logic [15:0] post_guard_reg;
  logic [15:0] pre_guard_reg;
  logic [7:0]  esc_char_reg;
  logic [15:0] rate_reg;
  logic [15:0] div_pend_reg;
  logic [15:0] rate_stored;
  logic [15:0] div_calc;
  logic        pend_valid_reg;
  logic [7:0]  pend_byte_reg;
  logic        is_esc, pre_ok, post_ok;
  logic        exit_cmd;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // pin synchroniser; idle line is high
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= serial_input_pin;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // a delivered byte always breaks silence; a low line only counts after
  // the escape character, since the character's own start bit would
  // otherwise wipe the silence it needs. limitation: pre silence thus
  // runs byte end to byte end and includes one frame time.
  assign activity = rx_valid ||
                    (!pin_s2_reg && (state_reg == SEC_ST_POST));

  // silence measured in whole guard units since last activity
  // pre and post silence timer
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tick_cnt_reg <= 32'h0000_0000;
      silence_reg  <= 16'h0000;
    end else if (activity) begin
      tick_cnt_reg <= 32'h0000_0000;
      silence_reg  <= 16'h0000;
    end else if (tick_cnt_reg == TICK_CYCLES - 1) begin
      tick_cnt_reg <= 32'h0000_0000;
      if (silence_reg != 16'hFFFF) begin
        silence_reg <= silence_reg + 16'h0001; // saturates
      end
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  assign is_esc  = rx_valid && (rx_byte == esc_char_reg);
  assign pre_ok  = silence_reg >= pre_guard_reg;
  assign post_ok = silence_reg >= post_guard_reg;
  assign exit_cmd = cmd_valid && (state_reg == SEC_ST_CMD) &&
                    (cmd.code == `SEC_CODE_EXIT);

  // sequence state
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= SEC_ST_DATA;
    end else begin
      case (state_reg)
        SEC_ST_DATA: begin
          if (is_esc && pre_ok) begin
            state_reg <= SEC_ST_POST;
          end
        end
        SEC_ST_POST: begin
          if (rx_valid) begin
            state_reg <= SEC_ST_DATA;
          end else if (post_ok) begin
            state_reg <= SEC_ST_CMD;
          end
        end
        SEC_ST_CMD: begin
          if (exit_cmd) begin
            state_reg <= SEC_ST_DATA;
          end
        end
        default: state_reg <= SEC_ST_DATA;
      endcase
    end
  end

  assign command_mode = (state_reg == SEC_ST_CMD);

  // data pass-through; on abort the held character leaves first and
  // the breaking byte one cycle later, so order is kept.
  // back-to-back bytes are limited by the serial rate, so one slot is
  // enough for the delayed byte.
  // aborted bytes become data
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      data_valid     <= 1'b0;
      data_byte      <= 8'h00;
      pend_valid_reg <= 1'b0;
      pend_byte_reg  <= 8'h00;
    end else begin
      data_valid     <= 1'b0;
      pend_valid_reg <= 1'b0;
      if (pend_valid_reg) begin
        data_valid <= 1'b1;
        data_byte  <= pend_byte_reg;
      end
      case (state_reg)
        SEC_ST_DATA: begin
          if (rx_valid && !(is_esc && pre_ok)) begin
            if (pend_valid_reg) begin
              pend_valid_reg <= 1'b1;
              pend_byte_reg  <= rx_byte;
            end else begin
              data_valid <= 1'b1;
              data_byte  <= rx_byte;
            end
          end
        end
        SEC_ST_POST: begin
          if (rx_valid) begin
            data_valid     <= 1'b1;
            data_byte      <= esc_char_reg;
            pend_valid_reg <= 1'b1;
            pend_byte_reg  <= rx_byte;
          end
        end
        default: ;
      endcase
    end
  end

  sec_rate_conv u_rate_conv (
    .rate_val    (cmd.data),
    .rate_stored (rate_stored),
    .divisor     (div_calc)
  );

  // parameter registers, written only in command mode
  // post guard, pre guard, character and rate reset values
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      post_guard_reg <= `SEC_RST_POST_GUARD;
      pre_guard_reg  <= `SEC_RST_PRE_GUARD;
      esc_char_reg   <= `SEC_RST_ESC_CHAR;
      rate_reg       <= RF_RATE_CODE;
      div_pend_reg   <= RST_DIV;
    end else if (cmd_valid && cmd.write && command_mode) begin
      case (cmd.code)
        `SEC_CODE_POST_GUARD: begin
          if (cmd.data >= `SEC_GUARD_MIN) begin
            post_guard_reg <= cmd.data;
          end
        end
        `SEC_CODE_PRE_GUARD: begin
          if (cmd.data >= `SEC_GUARD_MIN) begin
            pre_guard_reg <= cmd.data;
          end
        end
        `SEC_CODE_ESC_CHAR: begin
          if (cmd.data >= {8'h00, `SEC_CHAR_MIN} &&
              cmd.data <= {8'h00, `SEC_CHAR_MAX}) begin
            esc_char_reg <= cmd.data[7:0];
          end
        end
        `SEC_CODE_RATE: begin
          if (cmd.data <= `SEC_RATE_STD_MAX ||
              cmd.data >= `SEC_RATE_LIT_MIN) begin
            rate_reg     <= rate_stored;
            div_pend_reg <= div_calc;
          end
        end
        default: ;
      endcase
    end
  end

  // line timing only moves on exit; radio timing is not touched here
  // rate held until exit
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      uart_divisor <= RST_DIV;
      rate_active  <= RF_RATE_CODE;
    end else if (exit_cmd) begin
      uart_divisor <= div_pend_reg;
      rate_active  <= rate_reg;
    end
  end

  // answers: queries return stored values, writes echo an ack,
  // out-of-range or unknown codes answer with the error flag
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= cmd_valid && command_mode;
      if (cmd_valid && command_mode) begin
        rsp.data <= 16'h0000;
        rsp.len  <= 2'h0;
        rsp.err  <= 1'b0;
        case (cmd.code)
          `SEC_CODE_POST_GUARD: begin
            rsp.data <= post_guard_reg;
            rsp.len  <= `SEC_LEN_TWO;
            rsp.err  <= cmd.write && (cmd.data < `SEC_GUARD_MIN);
          end
          `SEC_CODE_PRE_GUARD: begin
            rsp.data <= pre_guard_reg;
            rsp.len  <= `SEC_LEN_TWO;
            rsp.err  <= cmd.write && (cmd.data < `SEC_GUARD_MIN);
          end
          `SEC_CODE_ESC_CHAR: begin
            rsp.data <= {8'h00, esc_char_reg};
            rsp.len  <= `SEC_LEN_ONE;
            rsp.err  <= cmd.write &&
                        (cmd.data < {8'h00, `SEC_CHAR_MIN} ||
                         cmd.data > {8'h00, `SEC_CHAR_MAX});
          end
          `SEC_CODE_RATE: begin
            rsp.data <= rate_reg;
            rsp.len  <= `SEC_LEN_TWO;
            rsp.err  <= cmd.write && cmd.data > `SEC_RATE_STD_MAX &&
                        cmd.data < `SEC_RATE_LIT_MIN;
          end
          `SEC_CODE_EXIT: ;
          default: rsp.err <= 1'b1;
        endcase
      end
    end
  end

endmodule : sec_escape_config

`default_nettype wire

// >>> sec_escape_config_chk.sv
/*
  checker: port timing of sec_escape_config.
  assumes it is bound into that module; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module sec_chk
  import sec_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic             sys_clk,      // clock
  input wire logic             arst_n,       // reset, low
  input wire logic             rx_valid,     // byte strobe
  input wire logic             cmd_valid,    // command strobe
  input wire sec_pkg::sec_cmd_s cmd,         // command
  input wire logic             rsp_valid,    // answer strobe
  input wire sec_pkg::sec_rsp_s rsp,         // answer
  input wire logic             data_valid,   // data strobe
  input wire logic             command_mode, // mode level
  input wire logic [15:0]      uart_divisor, // divisor
  input wire logic [15:0]      rate_active   // rate in use
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // quiet cycles since the last byte, saturating
  logic [31:0] quiet_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      quiet_reg <= 32'h0;
    end else if (rx_valid) begin
      quiet_reg <= 32'h0;
    end else if (quiet_reg != 32'hFFFF_FFFF) begin
      quiet_reg <= quiet_reg + 32'h1;
    end
  end

  sequence s_take;
    cmd_valid && command_mode;
  endsequence
  sequence s_exit;
    s_take ##0 (cmd.code == 8'h09);
  endsequence

  a_rsp_follows_cmd: assert property (s_take |=> rsp_valid)
    else $error("no answer one cycle after command");
  a_no_rsp_idle: assert property (!(cmd_valid && command_mode)
    |=> !rsp_valid)
    else $error("answer without accepted command");
  a_exit_mode: assert property (s_exit |=> !command_mode)
    else $error("command mode kept after exit");
  a_mode_holds: assert property (command_mode && !(cmd_valid
    && cmd.code == 8'h09) |=> command_mode)
    else $error("command mode left without exit");
  a_rate_waits: assert property ($changed(rate_active)
    |-> $fell(command_mode))
    else $error("rate changed before exit");
  a_div_waits: assert property ($changed(uart_divisor)
    |-> $fell(command_mode))
    else $error("divisor changed before exit");
  // slack of two covers the registered mode flag
  a_entry_quiet: assert property ($rose(command_mode)
    |-> quiet_reg >= 32'(2 * TICK_CYCLES) - 32'h2)
    else $error("command mode entered without silence");
  a_len_two: assert property (s_take ##0 (cmd.code inside
    {8'h04, 8'h05, 8'h15}) |=> rsp.len == 2'h2)
    else $error("two byte answer length wrong");
  a_len_one: assert property (s_take ##0 (cmd.code == 8'h13)
    |=> rsp.len == 2'h1 && rsp.data[15:8] == 8'h00)
    else $error("character answer length wrong");
  a_data_cause: assert property (data_valid
    |-> $past(rx_valid) || $past(rx_valid, 2))
    else $error("data byte without received byte");
  a_char_range: assert property (s_take ##0 (cmd.write
    && cmd.code == 8'h13 && cmd.data[7:0] < 8'h20) |=> rsp.err)
    else $error("low character accepted");
endmodule : sec_chk

bind sec_escape_config sec_chk #(.TICK_CYCLES(TICK_CYCLES)) u_sec_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .rx_valid(rx_valid),
  .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
  .data_valid(data_valid), .command_mode(command_mode),
  .uart_divisor(uart_divisor), .rate_active(rate_active)
);

`default_nettype wire

// >>> sec_host_model.sv
/*
  host model: line activity and received bytes toward the block.
  assumes its tasks are called at sys_clk falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module sec_host_model (
  input  wire logic  sys_clk,          // module clock
  output logic       serial_input_pin, // line, idle high
  output logic       rx_valid,         // byte strobe
  output logic [7:0] rx_byte           // byte
);
  initial begin
    serial_input_pin = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end

  task automatic quiet(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : quiet

  // byte values given as hex figures
  // shortened frame: line low, then strobe; stale byte inverted after
  task automatic send(input logic [7:0] b);
    @(negedge sys_clk);
    serial_input_pin = 1'b0;
    repeat (3) @(negedge sys_clk);
    serial_input_pin = 1'b1;
    rx_valid = 1'b1;
    rx_byte = b;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_byte = ~b;
  endtask : send
endmodule : sec_host_model

`default_nettype wire

// >>> sec_pkg.sv
/*
  types shared by the escape-sequence and serial rate block.
  assumes sec_regs.svh is on the include path.
*/
`include "sec_regs.svh"

package sec_pkg;

  typedef enum logic [1:0] {
    SEC_ST_DATA,
    SEC_ST_POST,
    SEC_ST_CMD
  } sec_state_e;

  // one binary command from the command-mode parser
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } sec_cmd_s;

  // answer to one command
  typedef struct packed {
    logic [15:0] data;
    logic [1:0]  len;
    logic        err;
  } sec_rsp_s;

  // standard rate code to bits per second
  function automatic logic [31:0] sec_std_bps(input logic [2:0] code);
    case (code)
      3'h0:    sec_std_bps = 32'h0000_04B0;
      3'h1:    sec_std_bps = 32'h0000_0960;
      3'h2:    sec_std_bps = 32'h0000_12C0;
      3'h3:    sec_std_bps = 32'h0000_2580;
      3'h4:    sec_std_bps = 32'h0000_4B00;
      3'h5:    sec_std_bps = 32'h0000_9600;
      default: sec_std_bps = 32'h0000_E100;
    endcase
  endfunction : sec_std_bps

  // nearest oversampled divisor for a bit rate, rounded
  function automatic logic [31:0] sec_divisor(input logic [31:0] bps);
    logic [31:0] base;
    base = 32'(`SEC_CLK_HZ / `SEC_UART_OVERSAMPLE);
    sec_divisor = (base + (bps >> 1)) / bps;
  endfunction : sec_divisor

endpackage : sec_pkg

// >>> sec_rate_conv.sv
/*
  rate converter: turns a written interface rate value into the divisor
  of the serial clock and the value to store: the code itself for a standard code, the achievable rate for a literal.
  assumes the value is already checked for a legal range.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sec_regs.svh"

module sec_rate_conv (
  input  wire logic [15:0] rate_val,    // value as written
  output logic      [15:0] rate_stored, // value that will be stored
  output logic      [15:0] divisor      // oversample clock divisor
);
  import sec_pkg::*;

  logic [31:0] bps;
  logic [31:0] div;
  logic [31:0] actual;

  // standard codes keep their code, literal rates round to the divider
  // nearest achievable rate
  always_comb begin
    if (rate_val <= `SEC_RATE_STD_MAX) begin
      bps = sec_std_bps(rate_val[2:0]);
    end else begin
      bps = {16'h0000, rate_val};
    end
    div = sec_divisor(bps);
    if (div == 32'h0000_0000) begin
      div = 32'h0000_0001; // guards against a zero divisor
    end
    actual = sec_divisor(div); // same rounding gives rate from divisor
    if (rate_val <= `SEC_RATE_STD_MAX) begin
      rate_stored = rate_val;
    end else if (actual > 32'h0000_FFFF) begin
      rate_stored = 16'hFFFF;
    end else begin
      rate_stored = actual[15:0];
    end
    divisor = div[15:0];
  end

endmodule : sec_rate_conv

`default_nettype wire

// >>> sec_regs.svh
/*
  constants of the escape-sequence and serial rate block: command codes,
  reset values, parameter limits and timing counts.
  assumes inclusion by any design file; the guard makes repeats harmless.
*/
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH

// binary command codes
`define SEC_CODE_PRE_GUARD    8'h04
`define SEC_CODE_POST_GUARD   8'h05
`define SEC_CODE_EXIT         8'h09
`define SEC_CODE_ESC_CHAR     8'h13
`define SEC_CODE_RATE         8'h15

// reset values
`define SEC_RST_POST_GUARD    16'h000A
`define SEC_RST_PRE_GUARD     16'h000A
`define SEC_RST_ESC_CHAR      8'h2B

// legal ranges
`define SEC_GUARD_MIN         16'h0002
`define SEC_CHAR_MIN          8'h20
`define SEC_CHAR_MAX          8'h7F
`define SEC_RATE_STD_MAX      16'h0006
`define SEC_RATE_LIT_MIN      16'h007D

// response lengths in bytes
`define SEC_LEN_ONE           2'h1
`define SEC_LEN_TWO           2'h2

// timing: guard unit and module clock
`define SEC_GUARD_UNIT_NS     100000000
`define SEC_CLK_PERIOD_NS     25
`define SEC_CLK_HZ            40000000
`define SEC_UART_OVERSAMPLE   16

`endif

// >>> tb_sec_escape_config.sv
/*
  testbench: escape entry, command answers and rate switching.
  assumes sec_host_model drives the receive side.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_sec_escape_config;
  import sec_pkg::*;
  localparam int unsigned TICK = 4;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  sec_cmd_s    cmd = '0;
  logic        pin, rx_valid, rsp_valid, data_valid, command_mode;
  logic [7:0]  rx_byte, data_byte;
  sec_rsp_s    rsp;
  logic [15:0] uart_divisor, rate_active;
  int          num_errors = 0;
  int          comparisons = 0;
  int          std_bps [7] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600};

  always #12.5 sys_clk = ~sys_clk;

  sec_host_model u_sec_host_model (.sys_clk(sys_clk),
    .serial_input_pin(pin), .rx_valid(rx_valid), .rx_byte(rx_byte));

  sec_escape_config #(.TICK_CYCLES(TICK), .RF_RATE_CODE(16'h0003))
  u_sec_escape_config (.sys_clk(sys_clk), .arst_n(arst_n),
    .serial_input_pin(pin), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
    .data_valid(data_valid), .data_byte(data_byte),
    .command_mode(command_mode), .uart_divisor(uart_divisor),
    .rate_active(rate_active));

  // divider runs at a sixteenth of 40 MHz
  function automatic logic [15:0] exp_div(input int bps);
    return 16'((2500000 + bps / 2) / bps);
  endfunction : exp_div
  function automatic logic [15:0] near_rate(input int bps);
    int d;
    d = (2500000 + bps / 2) / bps;
    return 16'((2500000 + d / 2) / d);
  endfunction : near_rate

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one command; answer sampled the cycle after it is taken
  task automatic command(input logic w, input logic [7:0] c,
                         input logic [15:0] d);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd = '{w, c, d};
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask : command

  task automatic query(input logic [7:0] c, input logic [15:0] exp,
                       input logic [1:0] len);
    command(1'b0, c, 16'h0);
    check(16'(rsp_valid), 16'h1);
    check(rsp.data, exp);
    check(16'(rsp.len), 16'(len));
  endtask : query

  task automatic write(input logic [7:0] c, input logic [15:0] d,
                       input logic err);
    command(1'b1, c, d);
    check(16'(rsp.err), 16'(err));
  endtask : write

  task automatic enter(input int units, input logic [7:0] ch);
    u_sec_host_model.quiet(units * TICK + 4);
    u_sec_host_model.send(ch);
    check(16'(data_valid), 16'h0);
    u_sec_host_model.quiet(units * TICK + 4);
    check(16'(command_mode), 16'h1);
  endtask : enter

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // watchdog well past the expected run of some 460 cycles
  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(16'(command_mode), 16'h0);
    check(rate_active, 16'h0003);
    check(uart_divisor, exp_div(9600));
    $display("test reset done");
    // escape without enough silence before it is plain data
    u_sec_host_model.send(8'h2B);
    check(16'(data_valid), 16'h1);
    check(16'(data_byte), 16'h002B);
    // stray byte in the after guard releases the held character
    u_sec_host_model.quiet(10 * TICK + 4);
    u_sec_host_model.send(8'h2B);
    u_sec_host_model.quiet(TICK);
    u_sec_host_model.send(8'h41);
    check(16'(data_byte), 16'h002B);
    @(negedge sys_clk);
    check(16'(data_valid), 16'h1);
    check(16'(data_byte), 16'h0041);
    check(16'(command_mode), 16'h0);
    $display("test escape abort done");
    enter(10, 8'h2B);
    query(8'h05, 16'h000A, 2'h2);
    query(8'h04, 16'h000A, 2'h2);
    query(8'h13, 16'h002B, 2'h1);
    query(8'h15, 16'h0003, 2'h2);
    write(8'h13, 16'h001F, 1'b1);
    write(8'h13, 16'h0080, 1'b1);
    write(8'h13, 16'h0025, 1'b0);
    query(8'h13, 16'h0025, 2'h1);
    write(8'h04, 16'h0001, 1'b1);
    write(8'h04, 16'h0002, 1'b0);
    write(8'h05, 16'h0001, 1'b1);
    write(8'h05, 16'hFFFF, 1'b0);
    query(8'h05, 16'hFFFF, 2'h2);
    write(8'h05, 16'h0002, 1'b0);
    write(8'h15, 16'h0007, 1'b1);
    write(8'h15, 16'h007C, 1'b1);
    command(1'b0, 8'h07, 16'h0);
    check(16'(rsp.err), 16'h1);
    $display("test parameters done");
    // every standard code, each applied only at exit
    for (int k = 0; k < 7; k++) begin
      write(8'h15, 16'(k), 1'b0);
      check(rate_active, k == 0 ? 16'h0003 : 16'(k - 1));
      command(1'b0, 8'h09, 16'h0);
      check(16'(command_mode), 16'h0);
      check(uart_divisor, exp_div(std_bps[k]));
      check(rate_active, 16'(k));
      command(1'b0, 8'h13, 16'h0);
      check(16'(rsp_valid), 16'h0);
      enter(2, 8'h25);
    end
    $display("test standard rates done");
    write(8'h15, 16'hE100, 1'b0);
    query(8'h15, near_rate(57600), 2'h2);
    write(8'h15, 16'h012C, 1'b0);
    query(8'h15, near_rate(300), 2'h2);
    command(1'b0, 8'h09, 16'h0);
    check(uart_divisor, exp_div(300));
    check(rate_active, near_rate(300));
    $display("test literal rates done");
    close_out();
  end
endmodule : tb_sec_escape_config

`default_nettype wire
